// ---- src/priv_mode_pkg.sv ----
// Shared types and constants for the privilege-mode transition checker
package priv_mode_pkg;

	// ------------------------------------------------------------------
	// Privilege modes, most privileged first: a larger code is less privileged
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_KERNEL,
		MODE_EXECUTIVE,
		MODE_SUPERVISOR,
		MODE_USER
	} mode_t;

	// ------------------------------------------------------------------
	// Triggering operations presented by decode and exception detection
	// ------------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_CHANGE_TO_KERNEL,
		OP_CHANGE_TO_EXECUTIVE,
		OP_CHANGE_TO_SUPERVISOR,
		OP_CHANGE_TO_USER,
		OP_RETURN_FROM_EXCEPTION,
		OP_IPL_WRITE,
		OP_TRAP_SUMMARY_WRITE,
		OP_TRAP_ENABLE_WRITE,
		OP_SWAP_TRAP_ENABLE,
		OP_EXCEPTION,
		OP_INTERRUPT,
		OP_MACHINE_CHECK,
		OP_HALT
	} op_t;

	// ------------------------------------------------------------------
	// Processor status word layout and reset values
	// ------------------------------------------------------------------
	localparam int          PSW_W          = 4;
	localparam int          IPL_W          = 3;
	localparam int          IPL_LSB        = 0;
	localparam int          IPL_MSB        = 2;
	localparam int          PSW_MODE_BIT   = 3;
	localparam logic        PSW_MODE_KERN  = 1'h0;
	localparam logic        PSW_MODE_OTHER = 1'h1;
	localparam logic [2:0]  IPL_RESET      = 3'h7;
	localparam logic [2:0]  IPL_MCHECK     = 3'h7;
	localparam mode_t       MODE_RESET     = MODE_KERNEL;

endpackage

// ---- src/priv_mode_decode.sv ----
// Combinational legality and next-state decode for one triggering operation
`timescale 1ns/1ps

module priv_mode_decode
	import priv_mode_pkg::*;
(
	input  wire mode_t             cur_mode,
	input  wire logic [IPL_W-1:0]  cur_ipl,
	input  wire op_t               op_code,
	input  wire mode_t             req_mode,
	input  wire logic [IPL_W-1:0]  req_ipl,
	output wire logic              legal,
	output wire mode_t             nxt_mode,
	output wire logic [IPL_W-1:0]  nxt_ipl,
	output wire logic              nxt_halt
);

	// ------------------------------------------------------------------
	// Mode qualifiers
	// ------------------------------------------------------------------
	wire logic in_kernel  = (cur_mode == MODE_KERNEL);
	wire logic in_user    = (cur_mode == MODE_USER);
	wire logic up_to_exec = (cur_mode != MODE_KERNEL);
	wire logic up_to_sup  = (cur_mode == MODE_SUPERVISOR) || in_user;

	// Return may keep or drop privilege, never gain it
	wire logic ret_ok = (req_mode >= cur_mode);

	// ------------------------------------------------------------------
	// Per-operation legality
	// ------------------------------------------------------------------
	wire logic to_kernel_op = (op_code == OP_CHANGE_TO_KERNEL) ||
	                          (op_code == OP_SWAP_TRAP_ENABLE) ||
	                          (op_code == OP_EXCEPTION) ||
	                          (op_code == OP_INTERRUPT) ||
	                          (op_code == OP_MACHINE_CHECK);
	wire logic kernel_only  = (op_code == OP_IPL_WRITE) ||
	                          (op_code == OP_TRAP_SUMMARY_WRITE) ||
	                          (op_code == OP_TRAP_ENABLE_WRITE) ||
	                          (op_code == OP_HALT);

	assign legal = to_kernel_op ||
	               (kernel_only && in_kernel) ||
	               ((op_code == OP_CHANGE_TO_EXECUTIVE) && up_to_exec) ||
	               ((op_code == OP_CHANGE_TO_SUPERVISOR) && up_to_sup) ||
	               ((op_code == OP_CHANGE_TO_USER) && in_user) ||
	               ((op_code == OP_RETURN_FROM_EXCEPTION) && ret_ok);

	// ------------------------------------------------------------------
	// Destination mode; every trap-like entry lands in kernel
	// ------------------------------------------------------------------
	assign nxt_mode = to_kernel_op                           ? MODE_KERNEL :
	                  (op_code == OP_CHANGE_TO_EXECUTIVE)    ? MODE_EXECUTIVE :
	                  (op_code == OP_CHANGE_TO_SUPERVISOR)   ? MODE_SUPERVISOR :
	                  (op_code == OP_CHANGE_TO_USER)         ? MODE_USER :
	                  (op_code == OP_RETURN_FROM_EXCEPTION)  ? req_mode :
	                  cur_mode;

	// Priority level: interrupts load the source level, checks go to the top
	assign nxt_ipl = (op_code == OP_INTERRUPT)             ? req_ipl :
	                 (op_code == OP_MACHINE_CHECK)         ? IPL_MCHECK :
	                 (op_code == OP_IPL_WRITE)             ? req_ipl :
	                 (op_code == OP_RETURN_FROM_EXCEPTION) ? req_ipl :
	                 cur_ipl;

	// Halt is only reachable from kernel
	assign nxt_halt = (op_code == OP_HALT) && in_kernel;

endmodule // priv_mode_decode

// ---- src/priv_mode_transition.sv ----
// Privilege-mode transition checker holding the mode, priority level and status word
`timescale 1ns/1ps

module priv_mode_transition
	import priv_mode_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              rst_b,
	input  wire logic              op_valid,
	input  wire op_t               op_code,
	input  wire mode_t             req_mode,
	input  wire logic [IPL_W-1:0]  req_ipl,
	output mode_t                  cur_mode_q,
	output logic [IPL_W-1:0]       ipl_q,
	output logic [PSW_W-1:0]       processor_status_word_q,
	output logic                   halted_q,
	output logic                   accepted_q,
	output logic                   illegal_op_q
);

	// ------------------------------------------------------------------
	// Decode of the presented operation
	// ------------------------------------------------------------------
	wire logic             dcd_legal;
	wire mode_t            dcd_mode;
	wire logic [IPL_W-1:0] dcd_ipl;
	wire logic             dcd_halt;

	priv_mode_decode u_decode (
		.cur_mode (cur_mode_q),
		.cur_ipl  (ipl_q),
		.op_code  (op_code),
		.req_mode (req_mode),
		.req_ipl  (req_ipl),
		.legal    (dcd_legal),
		.nxt_mode (dcd_mode),
		.nxt_ipl  (dcd_ipl),
		.nxt_halt (dcd_halt)
	);

	// ------------------------------------------------------------------
	// Next-state selection
	// ------------------------------------------------------------------
	// A halted core ignores everything until reset; it raises no exception
	// because nothing is left running to take it.
	wire logic             live       = op_valid && !halted_q;
	wire logic             take       = live && dcd_legal;
	wire logic             refuse     = live && !dcd_legal;
	wire mode_t            cur_mode_d = take ? dcd_mode : cur_mode_q;
	wire logic [IPL_W-1:0] ipl_d      = take ? dcd_ipl : ipl_q;
	wire logic             halted_d   = halted_q || (take && dcd_halt);
	wire logic             mode_bit_d = (cur_mode_d == MODE_KERNEL) ? PSW_MODE_KERN
	                                                                : PSW_MODE_OTHER;
	wire logic [PSW_W-1:0] psw_d      = {mode_bit_d, ipl_d};

	// ------------------------------------------------------------------
	// State registers
	// ------------------------------------------------------------------
	// Status word is registered alongside mode and level so it never lags them
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			cur_mode_q              <= MODE_RESET;
			ipl_q                   <= IPL_RESET;
			processor_status_word_q <= {PSW_MODE_KERN, IPL_RESET};
			halted_q                <= 1'h0;
		end else begin
			cur_mode_q              <= cur_mode_d;
			ipl_q                   <= ipl_d;
			processor_status_word_q <= psw_d;
			halted_q                <= halted_d;
		end
	end

	// Single-cycle outcome strobes toward decode and exception logic
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			accepted_q   <= 1'h0;
			illegal_op_q <= 1'h0;
		end else begin
			accepted_q   <= take;
			illegal_op_q <= refuse;
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	a_halt_from_kernel:
	assert property ($rose(halted_q) |-> $past(cur_mode_q) == MODE_KERNEL &&
	                 $past(op_code) == OP_HALT && $past(op_valid))
		else $error("halt entered from a mode other than kernel");

	a_halt_refused:
	assert property (op_valid && op_code == OP_HALT && !halted_q &&
	                 cur_mode_q != MODE_KERNEL |=> illegal_op_q && !halted_q)
		else $error("halt request outside kernel was not refused");

	a_return_no_raise:
	assert property (op_valid && !halted_q && op_code == OP_RETURN_FROM_EXCEPTION
	                 |=> cur_mode_q >= $past(cur_mode_q))
		else $error("return from exception raised privilege");

	a_exception_kernel:
	assert property (op_valid && !halted_q && op_code == OP_EXCEPTION
	                 |=> cur_mode_q == MODE_KERNEL && ipl_q == $past(ipl_q) && accepted_q)
		else $error("exception did not enter kernel at the same level");

	a_interrupt_kernel:
	assert property (op_valid && !halted_q && op_code == OP_INTERRUPT
	                 |=> cur_mode_q == MODE_KERNEL && ipl_q == $past(req_ipl))
		else $error("interrupt did not enter kernel at the source level");

	a_mcheck_kernel:
	assert property (op_valid && !halted_q && op_code == OP_MACHINE_CHECK
	                 |=> cur_mode_q == MODE_KERNEL && ipl_q == IPL_MCHECK)
		else $error("machine check did not enter kernel at top level");

	a_kernel_writes:
	assert property (op_valid && !halted_q && (op_code == OP_IPL_WRITE ||
	                 op_code == OP_TRAP_SUMMARY_WRITE || op_code == OP_TRAP_ENABLE_WRITE)
	                 |=> (accepted_q == ($past(cur_mode_q) == MODE_KERNEL)) &&
	                     cur_mode_q == $past(cur_mode_q))
		else $error("processor register write accepted outside kernel or moved mode");

	a_chg_mode_target:
	assert property (op_valid && !halted_q && op_code == OP_CHANGE_TO_SUPERVISOR &&
	                 cur_mode_q <= MODE_EXECUTIVE |=> illegal_op_q ##1 1'b1)
		else $error("change to supervisor accepted from a more privileged mode");

	a_chg_exec_ok:
	assert property (op_valid && !halted_q && op_code == OP_CHANGE_TO_EXECUTIVE &&
	                 cur_mode_q != MODE_KERNEL |=> cur_mode_q == MODE_EXECUTIVE)
		else $error("change to executive failed from a permitted mode");

	a_swap_kernel:
	assert property (op_valid && !halted_q && op_code == OP_SWAP_TRAP_ENABLE
	                 |=> cur_mode_q == MODE_KERNEL)
		else $error("swap trap enable did not leave the device in kernel");

	a_psw_level:
	assert property (processor_status_word_q[IPL_MSB:IPL_LSB] == ipl_q)
		else $error("status word level field disagrees with level");

	a_psw_mode_bit:
	assert property (processor_status_word_q[PSW_MODE_BIT] == (cur_mode_q != MODE_KERNEL))
		else $error("status word mode bit disagrees with current mode");

	a_illegal_hold:
	assert property (illegal_op_q |-> cur_mode_q == $past(cur_mode_q) &&
	                 ipl_q == $past(ipl_q) && !accepted_q)
		else $error("refused operation changed state");

	// ------------------------------------------------------------------
	// Halt and refusal details
	// ------------------------------------------------------------------
	// Halt is sticky and freezes all state, so nothing may pulse after it
	a_halt_sticky:
	assert property (halted_q |=> halted_q)
		else $error("halt state left without reset");

	a_halt_freezes:
	assert property (halted_q |=> !accepted_q && !illegal_op_q &&
	                 $stable(cur_mode_q) && $stable(ipl_q))
		else $error("halted core still answered an operation");

	a_halt_accepted:
	assert property ($rose(halted_q) |-> accepted_q && !illegal_op_q)
		else $error("halt entered without an accepted operation");

	a_halt_in_kernel:
	assert property (halted_q |-> cur_mode_q == MODE_KERNEL)
		else $error("halted outside kernel mode");

	a_halt_mode_hold:
	assert property (op_valid && !halted_q && op_code == OP_HALT &&
	                 cur_mode_q != MODE_KERNEL |=> cur_mode_q == $past(cur_mode_q))
		else $error("refused halt moved the mode");

	// ------------------------------------------------------------------
	// Return, traps and register writes
	// ------------------------------------------------------------------
	a_return_taken:
	assert property (op_valid && !halted_q && op_code == OP_RETURN_FROM_EXCEPTION &&
	                 req_mode >= cur_mode_q |=> accepted_q &&
	                 cur_mode_q == $past(req_mode) && ipl_q == $past(req_ipl))
		else $error("permitted return did not load the requested mode and level");

	a_return_refused:
	assert property (op_valid && !halted_q && op_code == OP_RETURN_FROM_EXCEPTION &&
	                 req_mode < cur_mode_q |=> illegal_op_q)
		else $error("return toward more privilege was not refused");

	a_exception_no_refuse:
	assert property (op_valid && !halted_q && op_code == OP_EXCEPTION |=> !illegal_op_q)
		else $error("exception was refused");

	a_interrupt_taken:
	assert property (op_valid && !halted_q && op_code == OP_INTERRUPT
	                 |=> accepted_q && !illegal_op_q)
		else $error("interrupt was not accepted");

	a_mcheck_taken:
	assert property (op_valid && !halted_q && op_code == OP_MACHINE_CHECK
	                 |=> accepted_q && !illegal_op_q)
		else $error("machine check was not accepted");

	a_level_write:
	assert property (op_valid && !halted_q && op_code == OP_IPL_WRITE &&
	                 cur_mode_q == MODE_KERNEL |=> ipl_q == $past(req_ipl))
		else $error("kernel level write did not load the level");

	a_trap_write_level:
	assert property (op_valid && !halted_q && (op_code == OP_TRAP_SUMMARY_WRITE ||
	                 op_code == OP_TRAP_ENABLE_WRITE) |=> ipl_q == $past(ipl_q))
		else $error("trap register write moved the level");

	a_write_refused:
	assert property (op_valid && !halted_q && (op_code == OP_IPL_WRITE ||
	                 op_code == OP_TRAP_SUMMARY_WRITE || op_code == OP_TRAP_ENABLE_WRITE) &&
	                 cur_mode_q != MODE_KERNEL |=> illegal_op_q && ipl_q == $past(ipl_q))
		else $error("register write outside kernel was not refused");

	// ------------------------------------------------------------------
	// Change-mode instructions and swap
	// ------------------------------------------------------------------
	a_chg_kernel_any:
	assert property (op_valid && !halted_q && op_code == OP_CHANGE_TO_KERNEL
	                 |=> cur_mode_q == MODE_KERNEL && ipl_q == $past(ipl_q) && accepted_q)
		else $error("change to kernel did not enter kernel");

	a_chg_exec_refused:
	assert property (op_valid && !halted_q && op_code == OP_CHANGE_TO_EXECUTIVE &&
	                 cur_mode_q == MODE_KERNEL |=> illegal_op_q && cur_mode_q == MODE_KERNEL)
		else $error("change to executive accepted from kernel");

	a_chg_sup_ok:
	assert property (op_valid && !halted_q && op_code == OP_CHANGE_TO_SUPERVISOR &&
	                 cur_mode_q >= MODE_SUPERVISOR
	                 |=> cur_mode_q == MODE_SUPERVISOR && accepted_q)
		else $error("change to supervisor failed from a permitted mode");

	a_chg_user_ok:
	assert property (op_valid && !halted_q && op_code == OP_CHANGE_TO_USER &&
	                 cur_mode_q == MODE_USER |=> cur_mode_q == MODE_USER && accepted_q)
		else $error("change to user failed from user");

	a_chg_user_refused:
	assert property (op_valid && !halted_q && op_code == OP_CHANGE_TO_USER &&
	                 cur_mode_q != MODE_USER
	                 |=> illegal_op_q && cur_mode_q == $past(cur_mode_q))
		else $error("change to user accepted from a more privileged mode");

	a_swap_level_kept:
	assert property (op_valid && !halted_q && op_code == OP_SWAP_TRAP_ENABLE
	                 |=> accepted_q && ipl_q == $past(ipl_q))
		else $error("swap trap enable was refused or moved the level");

	// A strobe only answers an operation that was live one cycle earlier
	a_pulse_source:
	assert property ((accepted_q || illegal_op_q) |-> $past(op_valid) && !$past(halted_q))
		else $error("outcome strobe without a live operation");

	a_pulse_exclusive:
	assert property (!(accepted_q && illegal_op_q))
		else $error("operation both accepted and refused");

	// ------------------------------------------------------------------
	// Coverage of main scenarios
	// ------------------------------------------------------------------
	c_halt_taken:
	cover property ($rose(halted_q));

	c_return_to_user:
	cover property (cur_mode_q == MODE_KERNEL ##1 cur_mode_q == MODE_USER);

	c_user_int_kernel:
	cover property (cur_mode_q == MODE_USER && op_valid && op_code == OP_INTERRUPT
	                ##1 cur_mode_q == MODE_KERNEL);

	c_illegal_seen:
	cover property (illegal_op_q);

	c_halt_refused:
	cover property (op_valid && op_code == OP_HALT && cur_mode_q != MODE_KERNEL ##1 illegal_op_q);

endmodule // priv_mode_transition

// ---- sim/op_source.sv ----
// Partner model: decode and exception detection presenting one operation at a time
`timescale 1ns/1ps

module op_source
	import priv_mode_pkg::*;
(
	input  wire logic              sys_clk,
	output logic                   op_valid,
	output op_t                    op_code,
	output mode_t                  req_mode,
	output logic [IPL_W-1:0]       req_ipl
);
	// --------------------------------------------------------------
	// Idle values at time zero
	// --------------------------------------------------------------
	initial begin
		op_valid = 1'b0;
		op_code  = OP_EXCEPTION;
		req_mode = MODE_USER;
		req_ipl  = 3'h0;
	end

	// Present one operation for exactly one taking edge, then scramble the
	// qualifiers so the checker cannot lean on stale values
	task automatic issue(input op_t op, input mode_t rm, input logic [IPL_W-1:0] ri);
		@(posedge sys_clk);
		#1;
		op_valid = 1'b1;
		op_code  = op;
		req_mode = rm;
		req_ipl  = ri;
		@(posedge sys_clk);
		#1;
		op_valid = 1'b0;
		op_code  = op_t'(~op_code);
		req_mode = mode_t'(~req_mode);
		req_ipl  = ~ri;
	endtask
endmodule // op_source

// ---- sim/priv_mode_transition_test.sv ----
// Self-checking testbench for the privilege-mode transition checker
`timescale 1ns/1ps

module priv_mode_transition_test;
	import priv_mode_pkg::*;
	logic              sys_clk;
	logic              rst_b;
	logic              op_valid;
	op_t               op_code;
	mode_t             req_mode;
	logic [IPL_W-1:0]  req_ipl;
	mode_t             cur_mode_q;
	logic [IPL_W-1:0]  ipl_q;
	logic [PSW_W-1:0]  psw_q;
	logic              halted_q;
	logic              accepted_q;
	logic              illegal_op_q;
	mode_t             exp_mode;
	logic [IPL_W-1:0]  exp_ipl;
	logic              exp_halt;
	int                n_fail;
	int                n_checks;

	priv_mode_transition DUT (.sys_clk(sys_clk), .rst_b(rst_b), .op_valid(op_valid),
		.op_code(op_code), .req_mode(req_mode), .req_ipl(req_ipl), .cur_mode_q(cur_mode_q),
		.ipl_q(ipl_q), .processor_status_word_q(psw_q), .halted_q(halted_q),
		.accepted_q(accepted_q), .illegal_op_q(illegal_op_q));
	op_source src (.sys_clk(sys_clk), .op_valid(op_valid), .op_code(op_code),
		.req_mode(req_mode), .req_ipl(req_ipl));

	// --------------------------------------------------------------
	// Clock, reporting and comparison
	// --------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	task automatic complete_run();
		if (n_fail == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Whole visible state: halt, status word, mode and level
	task automatic chk_state();
		chk({2'h0, halted_q, psw_q, cur_mode_q, ipl_q},
			{2'h0, exp_halt, exp_mode != MODE_KERNEL, exp_ipl, exp_mode, exp_ipl});
	endtask

	// Reset held in cycles; expectation rewinds to the reset state
	task automatic do_reset(input int cycles);
		@(posedge sys_clk);
		#1;
		rst_b = 1'b0;
		repeat (cycles) @(posedge sys_clk);
		#1;
		rst_b    = 1'b1;
		exp_mode = MODE_KERNEL;
		exp_ipl  = IPL_RESET;
		exp_halt = 1'b0;
		chk_state();
	endtask

	// --------------------------------------------------------------
	// One operation with its expected outcome worked out independently
	// --------------------------------------------------------------
	task automatic step(input op_t op, input mode_t rm, input logic [IPL_W-1:0] ri);
		logic ok;
		mode_t m;
		logic [IPL_W-1:0] l;
		ok = 1'b1;
		m  = MODE_KERNEL;
		l  = exp_ipl;
		case (op)
			OP_CHANGE_TO_EXECUTIVE, OP_CHANGE_TO_SUPERVISOR, OP_CHANGE_TO_USER: begin
				ok = exp_mode >= op[1:0];
				m  = mode_t'(op[1:0]);
			end
			OP_RETURN_FROM_EXCEPTION: begin
				ok = rm >= exp_mode;
				m  = rm;
				l  = ri;
			end
			OP_IPL_WRITE: begin
				ok = exp_mode == MODE_KERNEL;
				l  = ri;
			end
			OP_TRAP_SUMMARY_WRITE, OP_TRAP_ENABLE_WRITE, OP_HALT: ok = exp_mode == MODE_KERNEL;
			OP_INTERRUPT: l = ri;
			OP_MACHINE_CHECK: l = IPL_MCHECK;
			default: m = MODE_KERNEL;
		endcase
		src.issue(op, rm, ri);
		if (exp_halt) begin
			chk({10'h0, accepted_q, illegal_op_q}, 12'h0);
		end else begin
			chk({10'h0, accepted_q, illegal_op_q}, {10'h0, ok, !ok});
			if (ok) begin
				exp_mode = m;
				exp_ipl  = l;
				exp_halt = op == OP_HALT;
			end
		end
		chk_state();
	endtask

	// Reach a mode by way of kernel, at a middling level
	task automatic goto(input mode_t m);
		step(OP_EXCEPTION, MODE_KERNEL, 3'h0);
		step(OP_RETURN_FROM_EXCEPTION, m, 3'h4);
	endtask

	// --------------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------------
	// Every operation except return and halt from every mode
	task automatic test_table();
		for (int mi = 0; mi < 4; mi++)
			for (int oi = 0; oi < 12; oi++)
				if (oi != 4) begin
					goto(mode_t'(mi));
					step(op_t'(oi), MODE_KERNEL, 3'h2);
				end
	endtask

	// Return from each mode to each target: raising privilege is refused
	task automatic test_return();
		for (int mi = 0; mi < 4; mi++)
			for (int ri = 0; ri < 4; ri++) begin
				goto(mode_t'(mi));
				step(OP_RETURN_FROM_EXCEPTION, mode_t'(ri), 3'h1);
			end
	endtask

	// Halt refused outside kernel, taken in kernel, then one later exception ignored
	task automatic test_halt();
		for (int mi = 3; mi >= 0; mi--) begin
			goto(mode_t'(mi));
			step(OP_HALT, MODE_KERNEL, 3'h0);
		end
		step(OP_EXCEPTION, MODE_KERNEL, 3'h0);
	endtask

	// --------------------------------------------------------------
	// Main sequence and watchdog
	// --------------------------------------------------------------
	initial begin
		n_fail   = 0;
		n_checks = 0;
		rst_b    = 1'b0;
		do_reset(16);
		test_table();
		test_return();
		test_halt();
		do_reset(2);
		test_return();
		complete_run();
	end

	// Whole run is well under 1000 operations of two cycles each
	initial begin
		#100000;
		n_fail++;
		complete_run();
	end
endmodule // priv_mode_transition_test
